// ===== hdl/usp_consts.svh
// usp_consts.svh: addresses, field positions and reset values of the shadow data port
// assumes: included by bare name wherever registers are decoded
`ifndef USP_CONSTS_SVH
`define USP_CONSTS_SVH

// alias window: sixteen consecutive word locations, all the same data port
`define USP_ALIAS_BASE      32'h5000_1030
`define USP_ALIAS_LAST      32'h5000_106c
`define USP_DATA_PORT_5     32'h5000_1044
`define USP_ALIAS_COUNT     16

// block-local control and status words
`define USP_CTRL_ADDR       32'h5000_1080
`define USP_LSTAT_ADDR      32'h5000_1084
`define USP_ISTAT_ADDR      32'h5000_1088
`define USP_IMASK_ADDR      32'h5000_108c

// control word fields
`define USP_CTRL_FIFO_EN    0
`define USP_CTRL_IR_MODE    1
`define USP_CTRL_RESET      2'h0

// line status fields
`define USP_LS_DATA_READY   0
`define USP_LS_OVERRUN      1
`define USP_LS_TX_EMPTY     5

// interrupt status and mask fields
`define USP_IRQ_RX_CHAR     0
`define USP_IRQ_OVERRUN     1
`define USP_IRQ_TX_EMPTY    2
`define USP_IRQ_TX_DROP     3
`define USP_IRQ_WIDTH       4
`define USP_IRQ_RESET       4'h0

// data port layout
`define USP_DATA_MSB        7
`define USP_PORT_RESET      16'h0000
`define USP_FIFO_DEPTH      16

`endif

// ===== hdl/usp_pkg.sv
// usp_pkg.sv: types shared by the shadow data port, its checker and the line-side stand-in
// assumes: constants live in usp_consts.svh
package usp_pkg;

    // one character offered by a receive deframer
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } usp_char_t;

    // character presented to the transmit serializer
    typedef struct packed {
        logic       valid;
        logic       ir_mode;
        logic [7:0] data;
    } usp_tx_t;

    // line status flags mirrored outward
    typedef struct packed {
        logic data_ready;
        logic overrun;
        logic tx_empty;
    } usp_lstat_t;

endpackage

// ===== hdl/usp_fifo.sv
// usp_fifo.sv: synchronous character fifo with valid/ready on both sides
// assumes: one clock, flush and clock enable from the owning port logic
`timescale 1ns/1ns
module usp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic [AW-1:0]    nxt_wr_ptr;
    logic [AW-1:0]    nxt_rd_ptr;
    logic [AW:0]      nxt_count;
    logic             push;
    logic             pop;

    // full and empty straight from the occupancy count
    assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o  = mem[rd_ptr_ff];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // pointer wrap works for any depth, not only powers of two
    always_comb begin
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count  = count_ff;
        if (flush_i) begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_count  = '0;
        end else begin
            if (push) begin
                nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (ce_i) begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
        end
    end

    // storage has no reset: contents only matter while counted
    always_ff @(posedge core_clk_i) begin
        if (ce_i && push && !flush_i) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end
endmodule

// ===== hdl/usp_shadow_port.sv
// usp_shadow_port.sv: shadow rx/tx data port of a uart with control, status and irq
// assumes: deframers and serializer run on core_clk_i; plain register port, read data one cycle later
//
// Summary of operation
// - all sixteen word locations of the alias window reach the same data port.
// - read returns low byte from serial or infrared receiver, per mode.
// - read byte is only meaningful while data ready flag is set.
// - without fifos a new character overwrites unread byte and flags overrun.
// - with fifos a read returns and removes the receive fifo head.
// - full receive fifo keeps contents, drops new character, flags overrun.
// - write loads character sent on serial or infrared output, per mode.
// - without fifos a write clears the transmit holding empty flag.
// - without fifos further writes overwrite the pending transmit character.
// - with fifos writes are accepted until transmit fifo is full.
// - write into a full transmit fifo is discarded, contents unchanged.
`timescale 1ns/1ns
`include "usp_consts.svh"
module usp_shadow_port #(
    parameter int RX_DEPTH = `USP_FIFO_DEPTH,
    parameter int TX_DEPTH = `USP_FIFO_DEPTH
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 ce_i,
    input  wire logic [31:0]          addr_i,
    input  wire logic [31:0]          wr_data_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic [31:0]               rd_data_o,
    input  wire usp_pkg::usp_char_t   uart_rx_i,
    input  wire usp_pkg::usp_char_t   ir_rx_i,
    output usp_pkg::usp_tx_t          tx_o,
    input  wire logic                 tx_take_i,
    output usp_pkg::usp_lstat_t       lstat_o,
    output logic                      fifo_en_o,
    output logic                      irq_o
);
    // register state
    logic [1:0]                 ctrl_ff;
    logic [1:0]                 nxt_ctrl;
    logic [`USP_IRQ_WIDTH-1:0]  istat_ff;
    logic [`USP_IRQ_WIDTH-1:0]  nxt_istat;
    logic [`USP_IRQ_WIDTH-1:0]  imask_ff;
    logic [`USP_IRQ_WIDTH-1:0]  nxt_imask;
    logic [31:0]                rd_data_ff;
    logic [31:0]                nxt_rd_data;
    logic                       irq_ff;
    logic                       nxt_irq;

    // data path state
    logic [7:0]                 rx_hold_ff;
    logic [7:0]                 nxt_rx_hold;
    logic                       rx_ready_ff;
    logic                       nxt_rx_ready;
    logic [7:0]                 tx_hold_ff;
    logic [7:0]                 nxt_tx_hold;
    logic                       tx_empty_ff;
    logic                       nxt_tx_empty;
    logic                       overrun_ff;
    logic                       nxt_overrun;
    usp_pkg::usp_tx_t           tx_ff;
    usp_pkg::usp_tx_t           nxt_tx;
    usp_pkg::usp_lstat_t        lstat_ff;
    usp_pkg::usp_lstat_t        nxt_lstat;

    // decode and events
    logic                       sel_port;
    logic                       sel_ctrl;
    logic                       sel_lstat;
    logic                       sel_istat;
    logic                       sel_imask;
    logic                       port_rd;
    logic                       port_wr;
    logic                       fifo_en;
    logic                       mode_flip;
    usp_pkg::usp_char_t         rx_in;
    logic                       ev_rx_char;
    logic                       ev_overrun;
    logic                       ev_tx_empty;
    logic                       ev_tx_drop;
    logic                       cur_data_ready;
    logic                       cur_tx_empty;
    logic [7:0]                 port_byte;

    // fifo handshakes
    logic                       rxf_push;
    logic                       rxf_ready;
    logic                       rxf_valid;
    logic [7:0]                 rxf_head;
    logic                       rxf_pop;
    logic                       txf_push;
    logic                       txf_ready;
    logic                       txf_valid;
    logic [7:0]                 txf_head;
    logic                       txf_pop;
    logic                       tx_taken;

    // address decode: any aligned word of the alias window is the data port
    assign sel_port  = (addr_i >= `USP_ALIAS_BASE) && (addr_i <= `USP_ALIAS_LAST)
                       && (addr_i[1:0] == 2'h0);
    assign sel_ctrl  = (addr_i == `USP_CTRL_ADDR);
    assign sel_lstat = (addr_i == `USP_LSTAT_ADDR);
    assign sel_istat = (addr_i == `USP_ISTAT_ADDR);
    assign sel_imask = (addr_i == `USP_IMASK_ADDR);
    assign port_rd   = rd_i & sel_port;
    assign port_wr   = wr_i & sel_port;
    assign fifo_en   = ctrl_ff[`USP_CTRL_FIFO_EN];

    // a fifo mode change flushes both ways so no stale byte leaks
    assign mode_flip = wr_i & sel_ctrl & (wr_data_i[`USP_CTRL_FIFO_EN] != fifo_en);

    // receive source follows the line mode
    assign rx_in = ctrl_ff[`USP_CTRL_IR_MODE] ? ir_rx_i : uart_rx_i;

    // receive fifo steering
    assign rxf_push = fifo_en & rx_in.valid & ~mode_flip;
    assign rxf_pop  = fifo_en & port_rd;

    // transmit fifo steering; a full fifo simply refuses the push
    assign txf_push = fifo_en & port_wr & ~mode_flip;
    assign tx_taken = tx_take_i & tx_ff.valid;
    assign txf_pop  = fifo_en & tx_taken;

    usp_fifo #(
        .WIDTH (8),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .ce_i        (ce_i),
        .flush_i     (mode_flip),
        .in_valid_i  (rxf_push),
        .in_data_i   (rx_in.data),
        .in_ready_o  (rxf_ready),
        .out_valid_o (rxf_valid),
        .out_data_o  (rxf_head),
        .out_ready_i (rxf_pop)
    );

    usp_fifo #(
        .WIDTH (8),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .ce_i        (ce_i),
        .flush_i     (mode_flip),
        .in_valid_i  (txf_push),
        .in_data_i   (wr_data_i[`USP_DATA_MSB:0]),
        .in_ready_o  (txf_ready),
        .out_valid_o (txf_valid),
        .out_data_o  (txf_head),
        .out_ready_i (txf_pop)
    );

    // current flags as software should see them
    assign cur_data_ready = fifo_en ? rxf_valid : rx_ready_ff;
    assign cur_tx_empty   = fifo_en ? ~txf_valid : tx_empty_ff;
    assign port_byte      = fifo_en ? rxf_head : rx_hold_ff;

    // single-character receive holding, used with fifos off
    always_comb begin
        nxt_rx_hold  = rx_hold_ff;
        nxt_rx_ready = rx_ready_ff;
        if (mode_flip) begin
            nxt_rx_ready = 1'b0;
        end else if (!fifo_en) begin
            if (port_rd) begin
                nxt_rx_ready = 1'b0;
            end
            // arrival wins over a read in the same cycle
            if (rx_in.valid) begin
                nxt_rx_hold  = rx_in.data;
                nxt_rx_ready = 1'b1;
            end
        end
    end

    // receive events; overrun covers holding overwrite and fifo drop
    always_comb begin
        ev_rx_char = rx_in.valid & ~mode_flip;
        ev_overrun = 1'b0;
        if (rx_in.valid && !mode_flip) begin
            if (!fifo_en) begin
                ev_overrun = rx_ready_ff & ~port_rd;
            end else begin
                ev_overrun = ~rxf_ready;
            end
        end
    end

    // overrun flag: sticky until line status is read, new event wins
    always_comb begin
        nxt_overrun = overrun_ff;
        if (rd_i && sel_lstat) begin
            nxt_overrun = 1'b0;
        end
        if (ev_overrun) begin
            nxt_overrun = 1'b1;
        end
    end

    // single-character transmit holding, used with fifos off
    always_comb begin
        nxt_tx_hold  = tx_hold_ff;
        nxt_tx_empty = tx_empty_ff;
        if (mode_flip) begin
            nxt_tx_empty = 1'b1;
        end else if (!fifo_en) begin
            if (tx_taken) begin
                nxt_tx_empty = 1'b1;
            end
            // a write after the take reloads; a write while pending overwrites
            if (port_wr) begin
                nxt_tx_hold  = wr_data_i[`USP_DATA_MSB:0];
                nxt_tx_empty = 1'b0;
            end
        end
    end

    // transmit events
    assign ev_tx_drop  = port_wr & fifo_en & ~txf_ready & ~mode_flip;
    assign ev_tx_empty = ~lstat_ff.tx_empty & nxt_lstat.tx_empty;

    // char offered to the serializer; hidden a cycle after a pop
    // so back-to-back takes cannot grab one head twice
    always_comb begin
        nxt_tx         = tx_ff;
        nxt_tx.ir_mode = nxt_ctrl[`USP_CTRL_IR_MODE];
        if (mode_flip) begin
            nxt_tx.valid = 1'b0;
        end else if (fifo_en) begin
            nxt_tx.valid = txf_valid & ~txf_pop;
            nxt_tx.data  = txf_head;
        end else begin
            nxt_tx.valid = ~nxt_tx_empty;
            nxt_tx.data  = nxt_tx_hold;
        end
    end

    // mirrored line status; ready and empty one cycle behind the data path, overrun in step
    always_comb begin
        nxt_lstat.data_ready = cur_data_ready;
        nxt_lstat.overrun    = nxt_overrun;
        nxt_lstat.tx_empty   = cur_tx_empty;
    end

    // control and mask registers
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_imask = imask_ff;
        if (wr_i && sel_ctrl) begin
            nxt_ctrl = wr_data_i[1:0];
        end
        if (wr_i && sel_imask) begin
            nxt_imask = wr_data_i[`USP_IRQ_WIDTH-1:0];
        end
    end

    // interrupt status: cleared by its own read, a same-cycle event survives
    always_comb begin
        nxt_istat = istat_ff;
        if (rd_i && sel_istat) begin
            nxt_istat = '0;
        end
        if (ev_rx_char) begin
            nxt_istat[`USP_IRQ_RX_CHAR] = 1'b1;
        end
        if (ev_overrun) begin
            nxt_istat[`USP_IRQ_OVERRUN] = 1'b1;
        end
        if (ev_tx_empty) begin
            nxt_istat[`USP_IRQ_TX_EMPTY] = 1'b1;
        end
        if (ev_tx_drop) begin
            nxt_istat[`USP_IRQ_TX_DROP] = 1'b1;
        end
        nxt_irq = |(nxt_istat & nxt_imask);
    end

    // read mux; upper port bits and unmapped addresses read zero
    always_comb begin
        nxt_rd_data = 32'h0000_0000;
        if (rd_i) begin
            if (sel_port) begin
                nxt_rd_data[`USP_DATA_MSB:0] = port_byte;
            end else if (sel_ctrl) begin
                nxt_rd_data[1:0] = ctrl_ff;
            end else if (sel_lstat) begin
                nxt_rd_data[`USP_LS_DATA_READY] = cur_data_ready;
                nxt_rd_data[`USP_LS_OVERRUN]    = overrun_ff;
                nxt_rd_data[`USP_LS_TX_EMPTY]   = cur_tx_empty;
            end else if (sel_istat) begin
                nxt_rd_data[`USP_IRQ_WIDTH-1:0] = istat_ff;
            end else if (sel_imask) begin
                nxt_rd_data[`USP_IRQ_WIDTH-1:0] = imask_ff;
            end
        end
    end

    // register bank
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_ff    <= `USP_CTRL_RESET;
            imask_ff   <= `USP_IRQ_RESET;
            istat_ff   <= `USP_IRQ_RESET;
            irq_ff     <= 1'b0;
            rd_data_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            ctrl_ff    <= nxt_ctrl;
            imask_ff   <= nxt_imask;
            istat_ff   <= nxt_istat;
            irq_ff     <= nxt_irq;
            rd_data_ff <= nxt_rd_data;
        end
    end

    // data path bank; transmit holding starts empty
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_hold_ff  <= 8'h00;
            rx_ready_ff <= 1'b0;
            tx_hold_ff  <= 8'h00;
            tx_empty_ff <= 1'b1;
            overrun_ff  <= 1'b0;
            tx_ff       <= '0;
            lstat_ff    <= 3'h1;
        end else if (ce_i) begin
            rx_hold_ff  <= nxt_rx_hold;
            rx_ready_ff <= nxt_rx_ready;
            tx_hold_ff  <= nxt_tx_hold;
            tx_empty_ff <= nxt_tx_empty;
            overrun_ff  <= nxt_overrun;
            tx_ff       <= nxt_tx;
            lstat_ff    <= nxt_lstat;
        end
    end

    // outputs straight from flops
    assign rd_data_o = rd_data_ff;
    assign tx_o      = tx_ff;
    assign lstat_o   = lstat_ff;
    assign fifo_en_o = ctrl_ff[`USP_CTRL_FIFO_EN];
    assign irq_o     = irq_ff;
endmodule

// ===== test/usp_shadow_port_asserts.sv
// usp_shadow_port_asserts.sv: port-level checks of the shadow data port
// assumes: bound to usp_shadow_port; the bench keeps ce_i high
`timescale 1ns/1ns
`include "usp_consts.svh"
module usp_port_chk (
    input  wire logic                core_clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                ce_i,
    input  wire logic [31:0]         addr_i,
    input  wire logic [31:0]         wr_data_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    input  wire logic [31:0]         rd_data_o,
    input  wire usp_pkg::usp_char_t  uart_rx_i,
    input  wire usp_pkg::usp_char_t  ir_rx_i,
    input  wire usp_pkg::usp_tx_t    tx_o,
    input  wire logic                tx_take_i,
    input  wire usp_pkg::usp_lstat_t lstat_o,
    input  wire logic                fifo_en_o,
    input  wire logic                irq_o
);
    logic [2:0] quiet_ff;
    logic [2:0] nxt_quiet;
    logic       ctrl_wr;
    logic       port_wr;
    logic       rx_in;
    logic       calm;

    // a fifo mode change flushes both sides, so checks rest a few cycles after any control write
    always_comb begin
        ctrl_wr = wr_i && addr_i == `USP_CTRL_ADDR;
        port_wr = wr_i && addr_i >= `USP_ALIAS_BASE && addr_i <= `USP_ALIAS_LAST;
        rx_in = uart_rx_i.valid || ir_rx_i.valid;
        nxt_quiet = ctrl_wr ? 3'h4 : (quiet_ff != 3'h0) ? quiet_ff - 3'h1 : 3'h0;
        calm = quiet_ff == 3'h0 && !ctrl_wr;
    end

    // settle counter
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            quiet_ff <= 3'h4;
        end else begin
            quiet_ff <= nxt_quiet;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i || !ce_i);

    AST_RD_IDLE: assert property (!rd_i |=> rd_data_o == 32'h0)
        else $error("read data not zero idle");
    AST_HI_BYTES: assert property (rd_data_o[31:8] == 24'h0)
        else $error("upper bits not zero");
    AST_TX_LOAD: assert property (port_wr && !fifo_en_o && calm |=>
        tx_o.valid && tx_o.data == $past(wr_data_i[7:0]))
        else $error("write not offered");
    AST_TXE_CLEAR: assert property (port_wr && !fifo_en_o && calm && lstat_o.tx_empty
        |-> ##2 !lstat_o.tx_empty)
        else $error("tx empty not cleared");
    AST_RX_READY: assert property (rx_in && !fifo_en_o && calm |-> ##2 lstat_o.data_ready)
        else $error("data ready not raised");
    AST_OVERRUN: assert property (rx_in && !fifo_en_o && calm && lstat_o.data_ready
        && !rd_i && !$past(rd_i) |-> ##2 lstat_o.overrun)
        else $error("no overrun on overwrite");
    AST_TAKE_DROP: assert property (tx_o.valid && tx_take_i && !wr_i && calm |=> !tx_o.valid)
        else $error("offered after take");
    AST_TX_HOLD: assert property (tx_o.valid && !tx_take_i && !wr_i && calm
        |=> tx_o.valid && $stable(tx_o))
        else $error("offered char changed");
endmodule

bind usp_shadow_port usp_port_chk i_usp_port_chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .uart_rx_i(uart_rx_i), .ir_rx_i(ir_rx_i), .tx_o(tx_o), .tx_take_i(tx_take_i),
    .lstat_o(lstat_o), .fifo_en_o(fifo_en_o), .irq_o(irq_o));

// ===== test/usp_far_end.sv
// usp_far_end.sv: line-side stand-in, deframer pulses and serializer takes
// assumes: one clock shared with the port; bench calls send and sets stall
`timescale 1ns/1ns
module usp_far_end (
    input  wire logic               core_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               ir_sel_i,
    input  wire logic               stall_i,
    input  wire usp_pkg::usp_tx_t   tx_i,
    output usp_pkg::usp_char_t      uart_rx_o,
    output usp_pkg::usp_char_t      ir_rx_o,
    output logic                    take_o
);
    logic [7:0] got[$];

    initial begin
        uart_rx_o = '0;
        ir_rx_o = '0;
    end

    // one pulse on the mode's receiver; idle data inverted
    task automatic send(input logic [7:0] b);
        @(posedge core_clk_i);
        uart_rx_o <= '{valid: !ir_sel_i, data: b};
        ir_rx_o <= '{valid: ir_sel_i, data: b};
        @(posedge core_clk_i);
        uart_rx_o <= '{valid: 1'b0, data: ~b};
        ir_rx_o <= '{valid: 1'b0, data: ~b};
    endtask

    // takes spaced two cycles apart; stall models a slow serializer
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            take_o <= 1'b0;
        end else begin
            if (take_o && tx_i.valid) begin
                got.push_back(tx_i.data);
            end
            take_o <= tx_i.valid && !take_o && !stall_i;
        end
    end
endmodule

// ===== test/testbench.sv
// testbench.sv: register-port sequences against the shadow data port
// assumes: partner usp_far_end on the line side, checker bound elsewhere
`timescale 1ns/1ns
`include "usp_consts.svh"
module testbench;
    localparam int DEP = 4;
    logic                core_clk_i;
    logic                rst_b_i;
    logic                ce_i;
    logic                wr_i;
    logic                rd_i;
    logic                ir_sel;
    logic                stall;
    logic                take;
    logic                fifo_en;
    logic                irq;
    logic [31:0]         addr;
    logic [31:0]         wdata;
    logic [31:0]         rdata;
    logic [31:0]         v;
    usp_pkg::usp_char_t  urx;
    usp_pkg::usp_char_t  irx;
    usp_pkg::usp_tx_t    tx;
    usp_pkg::usp_lstat_t lstat;
    int                  n_mismatch = 0;
    int                  checks = 0;
    int                  cyc = 0;

    usp_shadow_port #(.RX_DEPTH(DEP), .TX_DEPTH(DEP)) i_usp_shadow_port (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr),
        .wr_data_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rdata),
        .uart_rx_i(urx), .ir_rx_i(irx), .tx_o(tx), .tx_take_i(take),
        .lstat_o(lstat), .fifo_en_o(fifo_en), .irq_o(irq));
    usp_far_end i_usp_far_end (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ir_sel_i(ir_sel), .stall_i(stall),
        .tx_i(tx), .uart_rx_o(urx), .ir_rx_o(irx), .take_o(take));

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bus cycles: one-cycle strobes, read data taken in the following cycle
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        cmp(what, exp, d);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic wait_got(input int n);
        for (int k = 0; k < 60 && i_usp_far_end.got.size() < n; k++) begin
            @(posedge core_clk_i);
        end
    endtask

    // 4 ns clock and a hang guard
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        rst_b_i = 1'b0;
        ce_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        ir_sel = 1'b0;
        stall = 1'b0;
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        rdc(`USP_LSTAT_ADDR, 32'h20, "lstat reset");
        rdc(`USP_DATA_PORT_5, 32'h0, "port reset");
        rdc(32'h5000_1090, 32'h0, "unmapped read");
        $display("test reset done");
        // every alias reaches the receive byte
        for (int i = 0; i < 16; i++) begin
            i_usp_far_end.send(8'(8'h10 + i));
            rdc(`USP_ALIAS_BASE + 32'(4 * i), 32'(8'h10 + i), "alias read");
        end
        i_usp_far_end.send(8'h5a);
        rdc(`USP_LSTAT_ADDR, 32'h21, "data ready");
        i_usp_far_end.send(8'ha5);
        rdc(`USP_LSTAT_ADDR, 32'h23, "overrun flag");
        rdc(`USP_DATA_PORT_5, 32'ha5, "overwritten byte");
        rdc(`USP_LSTAT_ADDR, 32'h20, "ready cleared");
        $display("test receive done");
        // infrared both ways, line side stalled
        wr(`USP_CTRL_ADDR, 32'h2);
        ir_sel <= 1'b1;
        stall <= 1'b1;
        i_usp_far_end.send(8'h3c);
        rdc(`USP_DATA_PORT_5, 32'h3c, "infrared byte");
        wr(`USP_DATA_PORT_5, 32'hffff_ffa5);
        cmp("tx infrared", 32'h3a5, {22'h0, tx.valid, tx.ir_mode, tx.data});
        rdc(`USP_LSTAT_ADDR, 32'h00, "empty cleared");
        wr(`USP_CTRL_ADDR, 32'h0);
        ir_sel <= 1'b0;
        wr(`USP_DATA_PORT_5, 32'h22);
        cmp("tx overwrite", 32'h222, {22'h0, tx.valid, tx.ir_mode, tx.data});
        stall <= 1'b0;
        wait_got(1);
        tick(6);
        cmp("tx count", 32'h1, 32'(i_usp_far_end.got.size()));
        cmp("tx sent", 32'h22, 32'(i_usp_far_end.got[0]));
        rdc(`USP_LSTAT_ADDR, 32'h20, "empty again");
        $display("test transmit done");
        // fifo mode: char past rx depth dropped
        wr(`USP_CTRL_ADDR, 32'h1);
        cmp("fifo enable", 32'h1, 32'(fifo_en));
        for (int i = 0; i <= DEP; i++) begin
            i_usp_far_end.send(8'(8'h80 + i));
        end
        rdc(`USP_LSTAT_ADDR, 32'h23, "fifo overrun");
        for (int i = 0; i < DEP; i++) begin
            rdc(`USP_DATA_PORT_5, 32'(8'h80 + i), "fifo head");
        end
        rdc(`USP_LSTAT_ADDR, 32'h20, "fifo drained");
        // tx fifo overfilled while the line stalls
        stall <= 1'b1;
        i_usp_far_end.got.delete();
        rd(`USP_ISTAT_ADDR, v);
        for (int i = 0; i <= DEP; i++) begin
            wr(`USP_DATA_PORT_5, 32'(8'hc0 + i));
        end
        rd(`USP_ISTAT_ADDR, v);
        cmp("drop event", 32'h1, 32'(v[`USP_IRQ_TX_DROP]));
        stall <= 1'b0;
        wait_got(DEP);
        tick(10);
        cmp("tx fifo count", 32'(DEP), 32'(i_usp_far_end.got.size()));
        for (int i = 0; i < DEP; i++) begin
            cmp("tx fifo order", 32'(8'hc0 + i), 32'(i_usp_far_end.got[i]));
        end
        $display("test fifo done");
        // irq: raised unmasked, cleared by read, quiet masked
        wr(`USP_IMASK_ADDR, 32'h1);
        rd(`USP_ISTAT_ADDR, v);
        i_usp_far_end.send(8'h77);
        tick(3);
        cmp("irq raised", 32'h1, 32'(irq));
        rd(`USP_ISTAT_ADDR, v);
        cmp("rx event", 32'h1, 32'(v[`USP_IRQ_RX_CHAR]));
        tick(2);
        cmp("irq cleared", 32'h0, 32'(irq));
        wr(`USP_IMASK_ADDR, 32'h0);
        i_usp_far_end.send(8'h78);
        tick(3);
        cmp("irq masked", 32'h0, 32'(irq));
        $display("test interrupt done");
        final_report();
    end
endmodule
